// File: rtl/pssc_pkg.sv
// Shared constants and types for the per-state supply configuration block.
// Operation
// - In awake state, outputs follow the awake-state configuration register.
// - Each sleep entry state applies its own register and dwells the programmed time.
// - Dwell field 20:16 is log2 of cycles; resets to 16.
// - Bit 14 set stops the processor tile clock; resets to zero.
// - Bit 9 picks analogue converter modulation: 0 pulse-width, 1 pulse-frequency.
// - Bit 8 picks core converter modulation: 0 pulse-width, 1 pulse-frequency.
// - Bit 5 drives the IO supply output enable.
// - Bit 4 drives the PLL linear regulator enable.
// - Bit 0 drives the writable core converter enable.
// - Bit 1 shows the analogue converter enable; read-only, writes ignored.
// - Awake register resets all enables on, clock running, pulse-width modulation.
// - First sleep register resets IO and analogue on, PLL and core off.
// - Second sleep register resets only the analogue converter enabled.
// - Sequencer state uses the documented 3-bit encoding zero to seven.
// - Waking states advance after minimum dwell and all enabled supplies good.
// - Applied settings and state are readable at configuration bit positions.
package pssc_pkg;

	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [7:0]  OFS_AWAKE        = 8'h18;
	localparam logic [7:0]  OFS_FIRST_SLEEP  = 8'h1c;
	localparam logic [7:0]  OFS_SECOND_SLEEP = 8'h20;
	localparam logic [7:0]  OFS_STATUS       = 8'h24;
	localparam int          BIT_CORE_EN      = 0;
	localparam int          BIT_ANA_EN       = 1;
	localparam int          BIT_PLL_EN       = 4;
	localparam int          BIT_IO_EN        = 5;
	localparam int          BIT_CORE_FMOD    = 8;
	localparam int          BIT_ANA_FMOD     = 9;
	localparam int          BIT_CLK_STOP     = 14;
	localparam int          DWELL_LSB        = 16;
	localparam int          DWELL_MSB        = 20;
	localparam int          STATE_LSB        = 16;
	localparam logic [31:0] RST_AWAKE        = 32'h0000_0033;
	localparam logic [31:0] RST_FIRST_SLEEP  = 32'h0010_0022;
	localparam logic [31:0] RST_SECOND_SLEEP = 32'h0010_0002;
	localparam logic [31:0] WMASK_AWAKE      = 32'h0000_4331;
	localparam logic [31:0] WMASK_SLEEP      = 32'h001f_4331;
	localparam logic [4:0]  WAKE_DWELL_LOG2  = 5'h04;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		PSSC_RESET              = 3'h0,
		PSSC_ASLEEP             = 3'h1,
		PSSC_FIRST_WAKE         = 3'h2,
		PSSC_SECOND_WAKE        = 3'h3,
		PSSC_AWAKE_WAIT         = 3'h4,
		PSSC_AWAKE              = 3'h5,
		PSSC_FIRST_SLEEP_ENTRY  = 3'h6,
		PSSC_SECOND_SLEEP_ENTRY = 3'h7
	} pssc_state_t;

	typedef struct packed {
		logic tile_clk_stop;
		logic analogue_conv_freq_mod;
		logic core_conv_freq_mod;
		logic io_supply_output_en;
		logic pll_linear_regulator_en;
		logic analogue_conv_en;
		logic core_conv_en;
	} pssc_cfg_t;

	typedef struct packed {
		logic io_good;
		logic pll_good;
		logic analogue_good;
		logic core_good;
	} pssc_good_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} pssc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pssc_axi_rsp_t;

	typedef struct packed {
		pssc_state_t st;
		logic [31:0] awake;
		logic [31:0] first_sleep;
		logic [31:0] second_sleep;
		pssc_cfg_t   applied;
		logic        aw_v;
		logic [7:0]  aw_addr;
		logic        w_v;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pssc_core_t;

	typedef struct packed {
		logic [31:0] cnt;
	} pssc_tmr_t;

	localparam pssc_cfg_t  CFG_RST  = 7'h0f;
	localparam pssc_tmr_t  TMR_RST  = 32'h0000_0000;
	localparam pssc_core_t CORE_RST = '{
		st: PSSC_RESET, awake: RST_AWAKE, first_sleep: RST_FIRST_SLEEP,
		second_sleep: RST_SECOND_SLEEP, applied: CFG_RST, aw_v: 1'b0,
		aw_addr: 8'h00, w_v: 1'b0, w_data: 32'h0000_0000, w_strb: 4'h0,
		bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: 32'h0000_0000,
		rresp: RESP_OKAY};

endpackage

// File: rtl/pssc_dwell_timer.sv
// Dwell counter that reports when two to the power n cycles have passed.
`timescale 1ns/1ps
module pssc_dwell_timer (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Control
	input  wire logic       restart,
	input  wire logic [4:0] log2_cycles,
	// Status
	output logic            expired
);

	pssc_pkg::pssc_tmr_t q;
	pssc_pkg::pssc_tmr_t d;
	logic [31:0]         target;

	// The count holds at the target so a stalled state keeps its expiry.
	// log2 dwell target
	assign target  = (32'h0000_0001 << log2_cycles) - 32'h0000_0001;
	assign expired = (q.cnt >= target);

	always_comb
	begin
		d = q;
		if (restart)
		begin
			d.cnt = 32'h0000_0000;
		end
		else if (!expired)
		begin
			d.cnt = q.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			q <= pssc_pkg::TMR_RST;
		end
		else
		begin
			q <= d;
		end
	end

endmodule

// File: rtl/pssc_supply_seq.sv
// Per-state supply configuration registers, sequencer and register slave.
`timescale 1ns/1ps
module pssc_supply_seq (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// Register bus
	input  wire pssc_pkg::pssc_axi_req_t axi_req,
	output pssc_pkg::pssc_axi_rsp_t    axi_rsp,
	// Sequencer requests and supply feedback
	input  wire logic                 sleep_req,
	input  wire logic                 wake_req,
	input  wire pssc_pkg::pssc_good_t supply_good,
	// Supply and clock controls and sequencer state
	output pssc_pkg::pssc_cfg_t       supply_ctl,
	output pssc_pkg::pssc_state_t     seq_state
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic pssc_pkg::pssc_cfg_t cfg_of(input logic [31:0] w);
		pssc_pkg::pssc_cfg_t c;
		c.tile_clk_stop           = w[pssc_pkg::BIT_CLK_STOP];
		c.analogue_conv_freq_mod  = w[pssc_pkg::BIT_ANA_FMOD];
		c.core_conv_freq_mod      = w[pssc_pkg::BIT_CORE_FMOD];
		c.io_supply_output_en     = w[pssc_pkg::BIT_IO_EN];
		c.pll_linear_regulator_en = w[pssc_pkg::BIT_PLL_EN];
		c.analogue_conv_en        = w[pssc_pkg::BIT_ANA_EN];
		c.core_conv_en            = w[pssc_pkg::BIT_CORE_EN];
		return c;
	endfunction

	function automatic logic [31:0] word_of(input pssc_pkg::pssc_cfg_t c);
		logic [31:0] w;
		w                           = 32'h0000_0000;
		w[pssc_pkg::BIT_CLK_STOP]   = c.tile_clk_stop;
		w[pssc_pkg::BIT_ANA_FMOD]   = c.analogue_conv_freq_mod;
		w[pssc_pkg::BIT_CORE_FMOD]  = c.core_conv_freq_mod;
		w[pssc_pkg::BIT_IO_EN]      = c.io_supply_output_en;
		w[pssc_pkg::BIT_PLL_EN]     = c.pll_linear_regulator_en;
		w[pssc_pkg::BIT_ANA_EN]     = c.analogue_conv_en;
		w[pssc_pkg::BIT_CORE_EN]    = c.core_conv_en;
		return w;
	endfunction

	// Byte lanes with strobes and writable bits take the new data.
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb,
		input logic [31:0] wmask
	);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
		begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		m = m & wmask;
		return (old & ~m) | (data & m);
	endfunction

	// Asleep and the transition states reuse the nearest documented setting.
	function automatic logic [31:0] word_for_state(
		input pssc_pkg::pssc_state_t st,
		input logic [31:0]           awake,
		input logic [31:0]           first_sleep,
		input logic [31:0]           second_sleep
	);
		logic [31:0] w;
		case (st)
			pssc_pkg::PSSC_FIRST_SLEEP_ENTRY:  w = first_sleep;
			pssc_pkg::PSSC_SECOND_SLEEP_ENTRY: w = second_sleep;
			pssc_pkg::PSSC_ASLEEP:             w = second_sleep;
			default:                           w = awake;
		endcase
		return w;
	endfunction

	// ************************************************************
	// State and timer
	// ************************************************************
	pssc_pkg::pssc_core_t q;
	pssc_pkg::pssc_core_t d;
	logic                 awready_c;
	logic                 wready_c;
	logic                 arready_c;
	logic                 all_good;
	logic                 restart;
	logic                 expired;
	logic [4:0]           dwell_log2;
	logic [31:0]          rd_word;

	assign awready_c = !q.aw_v && !q.bvalid;
	assign wready_c  = !q.w_v && !q.bvalid;
	assign arready_c = !q.rvalid;
	assign restart   = (d.st != q.st);

	assign all_good =
		(supply_good.core_good     || !q.applied.core_conv_en) &&
		(supply_good.analogue_good || !q.applied.analogue_conv_en) &&
		(supply_good.pll_good      || !q.applied.pll_linear_regulator_en) &&
		(supply_good.io_good       || !q.applied.io_supply_output_en);

	always_comb
	begin
		case (q.st)
			pssc_pkg::PSSC_FIRST_SLEEP_ENTRY:
				dwell_log2 = q.first_sleep[pssc_pkg::DWELL_MSB:pssc_pkg::DWELL_LSB];
			pssc_pkg::PSSC_SECOND_SLEEP_ENTRY:
				dwell_log2 = q.second_sleep[pssc_pkg::DWELL_MSB:pssc_pkg::DWELL_LSB];
			pssc_pkg::PSSC_FIRST_WAKE:  dwell_log2 = pssc_pkg::WAKE_DWELL_LOG2;
			pssc_pkg::PSSC_SECOND_WAKE: dwell_log2 = pssc_pkg::WAKE_DWELL_LOG2;
			default:                    dwell_log2 = 5'h00;
		endcase
	end

	pssc_dwell_timer u_pssc_dwell_timer (
		.core_clk    (core_clk),
		.rst         (rst),
		.restart     (restart),
		.log2_cycles (dwell_log2),
		.expired     (expired)
	);

	always_comb
	begin
		rd_word = word_of(q.applied);
		rd_word[pssc_pkg::STATE_LSB +: 3] = q.st;
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		d = q;
		// Write address and data are captured independently.
		if (awready_c && axi_req.awvalid)
		begin
			d.aw_v    = 1'b1;
			d.aw_addr = axi_req.awaddr;
		end
		if (wready_c && axi_req.wvalid)
		begin
			d.w_v    = 1'b1;
			d.w_data = axi_req.wdata;
			d.w_strb = axi_req.wstrb;
		end
		if (q.bvalid && axi_req.bready)
		begin
			d.bvalid = 1'b0;
		end
		if (q.aw_v && q.w_v && !q.bvalid)
		begin
			d.aw_v   = 1'b0;
			d.w_v    = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = pssc_pkg::RESP_OKAY;
			case (q.aw_addr)
				pssc_pkg::OFS_AWAKE:
					d.awake = merge(q.awake, q.w_data, q.w_strb, pssc_pkg::WMASK_AWAKE);
				pssc_pkg::OFS_FIRST_SLEEP:
					d.first_sleep = merge(q.first_sleep, q.w_data, q.w_strb,
						pssc_pkg::WMASK_SLEEP);
				pssc_pkg::OFS_SECOND_SLEEP:
					d.second_sleep = merge(q.second_sleep, q.w_data, q.w_strb,
						pssc_pkg::WMASK_SLEEP);
				pssc_pkg::OFS_STATUS:
					d.bresp = pssc_pkg::RESP_OKAY;
				default:
					d.bresp = pssc_pkg::RESP_SLVERR;
			endcase
		end
		// Read channel.
		if (q.rvalid && axi_req.rready)
		begin
			d.rvalid = 1'b0;
		end
		if (arready_c && axi_req.arvalid)
		begin
			d.rvalid = 1'b1;
			d.rresp  = pssc_pkg::RESP_OKAY;
			case (axi_req.araddr)
				pssc_pkg::OFS_AWAKE:        d.rdata = q.awake;
				pssc_pkg::OFS_FIRST_SLEEP:  d.rdata = q.first_sleep;
				pssc_pkg::OFS_SECOND_SLEEP: d.rdata = q.second_sleep;
				pssc_pkg::OFS_STATUS:       d.rdata = rd_word;
				default:
				begin
					d.rdata = 32'h0000_0000;
					d.rresp = pssc_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Power sequence.
		case (q.st)
			pssc_pkg::PSSC_RESET:
				d.st = pssc_pkg::PSSC_AWAKE_WAIT;
			pssc_pkg::PSSC_AWAKE_WAIT:
				if (all_good)
				begin
					d.st = pssc_pkg::PSSC_AWAKE;
				end
			pssc_pkg::PSSC_AWAKE:
				if (sleep_req)
				begin
					d.st = pssc_pkg::PSSC_FIRST_SLEEP_ENTRY;
				end
			pssc_pkg::PSSC_FIRST_SLEEP_ENTRY:
				if (expired)
				begin
					d.st = pssc_pkg::PSSC_SECOND_SLEEP_ENTRY;
				end
			pssc_pkg::PSSC_SECOND_SLEEP_ENTRY:
				if (expired)
				begin
					d.st = pssc_pkg::PSSC_ASLEEP;
				end
			pssc_pkg::PSSC_ASLEEP:
				if (wake_req)
				begin
					d.st = pssc_pkg::PSSC_FIRST_WAKE;
				end
			// wake on dwell and power good
			pssc_pkg::PSSC_FIRST_WAKE:
				if (expired && all_good)
				begin
					d.st = pssc_pkg::PSSC_SECOND_WAKE;
				end
			pssc_pkg::PSSC_SECOND_WAKE:
				if (expired && all_good)
				begin
					d.st = pssc_pkg::PSSC_AWAKE_WAIT;
				end
			default:
				d.st = pssc_pkg::PSSC_RESET;
		endcase
		d.applied = cfg_of(word_for_state(d.st, d.awake, d.first_sleep, d.second_sleep));
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			q <= pssc_pkg::CORE_RST;
		end
		else
		begin
			q <= d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign supply_ctl      = q.applied;
	assign seq_state       = q.st;
	assign axi_rsp.awready = awready_c;
	assign axi_rsp.wready  = wready_c;
	assign axi_rsp.bvalid  = q.bvalid;
	assign axi_rsp.bresp   = q.bresp;
	assign axi_rsp.arready = arready_c;
	assign axi_rsp.rvalid  = q.rvalid;
	assign axi_rsp.rdata   = q.rdata;
	assign axi_rsp.rresp   = q.rresp;

	// ************************************************************
	// Assertions
	// ************************************************************
	logic [31:0] stay_cnt_q;
	// Cycles spent in the current state, for checking dwell lengths.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stay_cnt_q <= 32'h0000_0000;
		end
		else
		begin
			stay_cnt_q <= restart ? 32'h0000_0000 : stay_cnt_q + 32'h0000_0001;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_awake_outputs;
		q.st == pssc_pkg::PSSC_AWAKE |-> supply_ctl == cfg_of(q.awake);
	endproperty
	a_awake_outputs: assert property (p_awake_outputs)
		else $error("awake outputs differ from awake register");
	property p_sleep_outputs;
		q.st == pssc_pkg::PSSC_FIRST_SLEEP_ENTRY |->
			supply_ctl.core_conv_en == q.first_sleep[pssc_pkg::BIT_CORE_EN] &&
			supply_ctl.io_supply_output_en == q.first_sleep[pssc_pkg::BIT_IO_EN];
	endproperty
	a_sleep_outputs: assert property (p_sleep_outputs)
		else $error("first sleep outputs differ from its register");
	property p_dwell_len;
		(q.st == pssc_pkg::PSSC_FIRST_SLEEP_ENTRY && restart) |->
			stay_cnt_q == (32'h0000_0001 <<
				q.first_sleep[pssc_pkg::DWELL_MSB:pssc_pkg::DWELL_LSB]) - 32'h0000_0001;
	endproperty
	a_dwell_len: assert property (p_dwell_len)
		else $error("first sleep dwell length wrong");
	property p_clk_stop;
		(q.st == pssc_pkg::PSSC_AWAKE && q.awake[pssc_pkg::BIT_CLK_STOP]) ##1
			(q.st == pssc_pkg::PSSC_AWAKE && $stable(q.awake)) |->
			supply_ctl.tile_clk_stop;
	endproperty
	a_clk_stop: assert property (p_clk_stop)
		else $error("tile clock not stopped while awake register asks");
	property p_io_second_sleep;
		q.st == pssc_pkg::PSSC_SECOND_SLEEP_ENTRY |->
			supply_ctl.io_supply_output_en == q.second_sleep[pssc_pkg::BIT_IO_EN];
	endproperty
	a_io_second_sleep: assert property (p_io_second_sleep)
		else $error("IO supply enable wrong in second sleep");
	property p_ana_readonly;
		q.awake[pssc_pkg::BIT_ANA_EN] && q.first_sleep[pssc_pkg::BIT_ANA_EN] &&
			q.second_sleep[pssc_pkg::BIT_ANA_EN];
	endproperty
	a_ana_readonly: assert property (p_ana_readonly)
		else $error("read-only analogue enable changed");
	property p_wake_good;
		(q.st == pssc_pkg::PSSC_FIRST_WAKE && d.st == pssc_pkg::PSSC_SECOND_WAKE) |->
			all_good && stay_cnt_q >= 32'h0000_000f;
	endproperty
	a_wake_good: assert property (p_wake_good)
		else $error("left first wake early or with a bad supply");
	property p_status_state;
		(arready_c && axi_req.arvalid && axi_req.araddr == pssc_pkg::OFS_STATUS) |=>
			q.rdata[pssc_pkg::STATE_LSB +: 3] == $past(q.st);
	endproperty
	a_status_state: assert property (p_status_state)
		else $error("status read shows wrong state");
	property p_sleep_chain;
		(q.st == pssc_pkg::PSSC_SECOND_SLEEP_ENTRY && expired) |=>
			q.st == pssc_pkg::PSSC_ASLEEP && supply_ctl == cfg_of(q.second_sleep);
	endproperty
	a_sleep_chain: assert property (p_sleep_chain)
		else $error("second sleep expiry did not reach asleep");
	property p_reserved_zero;
		(q.first_sleep & ~pssc_pkg::WMASK_SLEEP & ~32'h0000_0002) == 32'h0000_0000 &&
			(q.awake & ~pssc_pkg::WMASK_AWAKE & ~32'h0000_0002) == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved register bit became set");

	c_sleep_entry: cover property (q.st == pssc_pkg::PSSC_AWAKE ##1
		q.st == pssc_pkg::PSSC_FIRST_SLEEP_ENTRY);
	c_asleep: cover property (q.st == pssc_pkg::PSSC_ASLEEP);
	c_rewake: cover property (q.st == pssc_pkg::PSSC_SECOND_WAKE ##1
		q.st == pssc_pkg::PSSC_AWAKE_WAIT);
	c_write_resp: cover property (q.bvalid && axi_req.bready);

endmodule

// File: dv/pssc_supply_model.sv
// Behavioural supply regulators that report power good after a settling delay.
`timescale 1ns/1ps
module pssc_supply_model #(
	parameter int FAST_DLY = 3,
	parameter int SLOW_DLY = 40
) (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst,
	// Controls from the sequencer and the bench
	input  wire pssc_pkg::pssc_cfg_t supply_ctl,
	input  wire logic                slow,
	// Power good back to the sequencer
	output pssc_pkg::pssc_good_t     supply_good
);
	pssc_pkg::pssc_cfg_t prev_q;
	int                  cnt_q;
	logic                up;

	// Any change of the enables restarts the settling time of every supply.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			prev_q <= '0;
			cnt_q  <= 0;
		end
		else
		begin
			prev_q <= supply_ctl;
			cnt_q  <= (supply_ctl != prev_q) ? 0 : cnt_q + 1;
		end
	end

	// A supply that is switched off never reports good.
	assign up = cnt_q >= (slow ? SLOW_DLY : FAST_DLY);
	assign supply_good = '{io_good: up & supply_ctl.io_supply_output_en,
		pll_good: up & supply_ctl.pll_linear_regulator_en,
		analogue_good: up & supply_ctl.analogue_conv_en,
		core_good: up & supply_ctl.core_conv_en};
endmodule

// File: dv/pssc_supply_seq_tb.sv
// Self-checking bench for the per-state supply configuration block.
`timescale 1ns/1ps
`define PSSC_CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("ERROR at %0t: got %0h expected %0h", $time, (got), (exp)); \
		end \
	end
module pssc_supply_seq_tb;
	logic                    core_clk;
	logic                    rst;
	logic                    sleep_req;
	logic                    wake_req;
	logic                    slow;
	pssc_pkg::pssc_axi_req_t axi_req;
	pssc_pkg::pssc_axi_rsp_t axi_rsp;
	pssc_pkg::pssc_good_t    supply_good;
	pssc_pkg::pssc_cfg_t     supply_ctl;
	pssc_pkg::pssc_state_t   seq_state;
	int                      fail_count;
	int                      samples_checked;
	int                      n;

	pssc_supply_seq u_pssc_supply_seq (.core_clk(core_clk), .rst(rst), .axi_req(axi_req),
		.axi_rsp(axi_rsp), .sleep_req(sleep_req), .wake_req(wake_req),
		.supply_good(supply_good), .supply_ctl(supply_ctl), .seq_state(seq_state));
	pssc_supply_model u_pssc_supply_model (.core_clk(core_clk), .rst(rst),
		.supply_ctl(supply_ctl), .slow(slow), .supply_good(supply_good));

	always #20 core_clk = ~core_clk;

	// ************************************************************
	// Reporting
	// ************************************************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic timeout();
		fail_count++;
		$display("ERROR at %0t: wait limit reached", $time);
		close_out();
	endtask

	// ************************************************************
	// Register bus and sequencer helpers
	// ************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic ta, tw, tb, done;
		done = 1'b0;
		@(posedge core_clk);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr  <= a;
		axi_req.wvalid  <= 1'b1;
		axi_req.wdata   <= d;
		axi_req.wstrb   <= s;
		axi_req.bready  <= 1'b1;
		for (int i = 0; i < 64 && !done; i++)
		begin
			@(negedge core_clk);
			ta = axi_req.awvalid && axi_rsp.awready;
			tw = axi_req.wvalid && axi_rsp.wready;
			tb = axi_req.bready && axi_rsp.bvalid;
			if (tb)
				`PSSC_CHK(axi_rsp.bresp, er)
			@(posedge core_clk);
			if (ta)
				axi_req.awvalid <= 1'b0;
			if (tw)
				axi_req.wvalid <= 1'b0;
			if (tb)
			begin
				axi_req.bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			timeout();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr, done;
		done = 1'b0;
		@(posedge core_clk);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr  <= a;
		axi_req.rready  <= 1'b1;
		for (int i = 0; i < 64 && !done; i++)
		begin
			@(negedge core_clk);
			ta = axi_req.arvalid && axi_rsp.arready;
			tr = axi_req.rready && axi_rsp.rvalid;
			if (tr)
			begin
				`PSSC_CHK(axi_rsp.rdata, ed)
				`PSSC_CHK(axi_rsp.rresp, er)
			end
			@(posedge core_clk);
			if (ta)
				axi_req.arvalid <= 1'b0;
			if (tr)
			begin
				axi_req.rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			timeout();
	endtask

	task automatic wait_for(input pssc_pkg::pssc_state_t s);
		for (int i = 0; i < 3000 && seq_state !== s; i++)
		begin
			@(posedge core_clk);
			#1;
		end
		if (seq_state !== s)
			timeout();
	endtask

	// Counts the edges spent in the present state, sampling just after each edge.
	task automatic dwell(input pssc_pkg::pssc_state_t s, output int c);
		c = 0;
		while (seq_state === s && c < 3000)
		begin
			@(posedge core_clk);
			#1;
			c++;
		end
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial
	begin
		core_clk        = 1'b0;
		rst             = 1'b1;
		axi_req         = '0;
		sleep_req       = 1'b0;
		wake_req        = 1'b0;
		slow            = 1'b0;
		fail_count      = 0;
		samples_checked = 0;
		repeat (9) @(posedge core_clk);
		#1;
		`PSSC_CHK(supply_ctl, 7'h0f)
		`PSSC_CHK(seq_state, 3'h0)
		@(posedge core_clk);
		rst <= 1'b0;
		wait_for(pssc_pkg::PSSC_AWAKE);
		`PSSC_CHK(supply_ctl, 7'h0f)
		rd(pssc_pkg::OFS_AWAKE, 32'h0000_0033, pssc_pkg::RESP_OKAY);
		rd(pssc_pkg::OFS_FIRST_SLEEP, 32'h0010_0022, pssc_pkg::RESP_OKAY);
		rd(pssc_pkg::OFS_SECOND_SLEEP, 32'h0010_0002, pssc_pkg::RESP_OKAY);
		$display("test reset_values done");

		wr(pssc_pkg::OFS_AWAKE, 32'hffff_ff00, 4'h3, pssc_pkg::RESP_OKAY);
		rd(pssc_pkg::OFS_AWAKE, 32'h0000_4302, pssc_pkg::RESP_OKAY);
		@(posedge core_clk);
		#1;
		`PSSC_CHK(supply_ctl, 7'h72)
		wr(pssc_pkg::OFS_AWAKE, 32'hffff_ffff, 4'h1, pssc_pkg::RESP_OKAY);
		rd(pssc_pkg::OFS_AWAKE, 32'h0000_4333, pssc_pkg::RESP_OKAY);
		@(posedge core_clk);
		#1;
		`PSSC_CHK(supply_ctl, 7'h7f)
		wr(pssc_pkg::OFS_AWAKE, 32'h0000_0031, 4'hf, pssc_pkg::RESP_OKAY);
		@(posedge core_clk);
		#1;
		`PSSC_CHK(supply_ctl, 7'h0f)
		$display("test awake_fields done");

		rd(8'h24, 32'h0005_0033, pssc_pkg::RESP_OKAY);
		wr(8'h24, 32'hffff_ffff, 4'hf, pssc_pkg::RESP_OKAY);
		rd(8'h24, 32'h0005_0033, pssc_pkg::RESP_OKAY);
		rd(8'h40, 32'h0000_0000, pssc_pkg::RESP_SLVERR);
		rd(8'h19, 32'h0000_0000, pssc_pkg::RESP_SLVERR);
		wr(8'h40, 32'hffff_ffff, 4'hf, pssc_pkg::RESP_SLVERR);
		$display("test status_and_errors done");

		wr(pssc_pkg::OFS_FIRST_SLEEP, 32'h0002_0321, 4'hf, pssc_pkg::RESP_OKAY);
		rd(pssc_pkg::OFS_FIRST_SLEEP, 32'h0002_0323, pssc_pkg::RESP_OKAY);
		wr(pssc_pkg::OFS_SECOND_SLEEP, 32'hffe1_4000, 4'hf, pssc_pkg::RESP_OKAY);
		rd(pssc_pkg::OFS_SECOND_SLEEP, 32'h0001_4002, pssc_pkg::RESP_OKAY);
		@(posedge core_clk);
		sleep_req <= 1'b1;
		@(posedge core_clk);
		sleep_req <= 1'b0;
		#1;
		`PSSC_CHK(seq_state, 3'h6)
		`PSSC_CHK(supply_ctl, 7'h3b)
		dwell(pssc_pkg::PSSC_FIRST_SLEEP_ENTRY, n);
		`PSSC_CHK(n, 4)
		`PSSC_CHK(seq_state, 3'h7)
		`PSSC_CHK(supply_ctl, 7'h42)
		dwell(pssc_pkg::PSSC_SECOND_SLEEP_ENTRY, n);
		`PSSC_CHK(n, 2)
		`PSSC_CHK(seq_state, 3'h1)
		$display("test sleep_entry done");

		@(posedge core_clk);
		slow     <= 1'b1;
		wake_req <= 1'b1;
		@(posedge core_clk);
		wake_req <= 1'b0;
		#1;
		`PSSC_CHK(seq_state, 3'h2)
		dwell(pssc_pkg::PSSC_FIRST_WAKE, n);
		`PSSC_CHK(n >= 40, 1'b1)
		`PSSC_CHK(seq_state, 3'h3)
		dwell(pssc_pkg::PSSC_SECOND_WAKE, n);
		`PSSC_CHK(n >= 16, 1'b1)
		wait_for(pssc_pkg::PSSC_AWAKE);
		`PSSC_CHK(supply_ctl, 7'h0f)
		$display("test wake_return done");
		close_out();
	end
endmodule
